// [rtl/rke_consts.vh]
// constants shared by the remote entry receiver control files
`ifndef RKE_CONSTS_VH
`define RKE_CONSTS_VH
// register byte offsets
`define RKE_OFS_CTRL     8'h00
`define RKE_OFS_STATUS   8'h04
`define RKE_OFS_SLOT0    8'h08
`define RKE_OFS_SLOT1    8'h0c
`define RKE_OFS_LAST     8'h10
// control field positions and reset value
`define RKE_CTRL_EN      0
`define RKE_CTRL_RELOCK  1
`define RKE_CTRL_CONFIRM 2
`define RKE_CTRL_RST     32'h0000_0007
// status field positions
`define RKE_ST_REGMODE   0
`define RKE_ST_INHIBIT   1
`define RKE_ST_RELOCK    2
`define RKE_ST_DOME      3
`define RKE_ST_MISCNT    8
// data code layout
`define RKE_CODE_BITS    51
`define RKE_SECRET_BITS  21
`define RKE_SYSID_BITS   25
`define RKE_CMD_BIT      21
`define RKE_SYSID_LSB    22
`define RKE_FACTORY_CODE 21'h0a5a5a
// timing
`define RKE_CLK_HZ       50000000
`define RKE_TICK_US      1000
`define RKE_TICK_CYC     ((`RKE_CLK_HZ / 1000000) * `RKE_TICK_US)
`define RKE_CONFIRM_MS   3000
`define RKE_RELOCK_MS    30000
`define RKE_MISWIN_MS    60000
`define RKE_INHIBIT_MS   600000
`define RKE_FLASH_MS     250
`define RKE_DRIVE_MS     200
`define RKE_PRESS_GAP_MS 100
`define RKE_MIS_LIMIT    30
`endif

// [rtl/rke_frame_rx.v]
// serial data-code receiver: pin synchronisers and 51-bit shift register
`timescale 1ns/100ps
`default_nettype none
`include "rke_consts.vh"
module rke_frame_rx #(
  parameter NB = `RKE_CODE_BITS
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          rx_gate,
  input  wire          rx_bclk,
  input  wire          rx_data,
  output reg           code_vld_r,
  output reg  [NB-1:0] code_r
);
  reg [2:0]    s1_r;
  reg [2:0]    s2_r;
  reg [1:0]    d3_r;
  reg [NB-1:0] shf_r;
  reg [5:0]    cnt_r;
  wire         gate_s = s2_r[0];
  wire         bclk_s = s2_r[1];
  wire         data_s = s2_r[2];

  // two-stage synchroniser, then one more stage for edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      d3_r <= 2'h0;
    end else begin
      s1_r <= {rx_data, rx_bclk, rx_gate};
      s2_r <= s1_r;
      d3_r <= {bclk_s, gate_s};
    end
  end

  // shift msb first while the gate is high; a code counts only with exactly NB bits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shf_r      <= {NB{1'b0}};
      cnt_r      <= 6'h00;
      code_vld_r <= 1'b0;
      code_r     <= {NB{1'b0}};
    end else begin
      code_vld_r <= 1'b0;
      if (gate_s && bclk_s && !d3_r[1]) begin
        shf_r <= {shf_r[NB-2:0], data_s};
        if (cnt_r != 6'h3f)
          cnt_r <= cnt_r + 6'h01;
      end
      if (!gate_s && d3_r[0]) begin
        cnt_r <= 6'h00;
        if (cnt_r == NB[5:0]) begin
          code_vld_r <= 1'b1;
          code_r     <= shf_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/rke_code_store.v]
// two-slot secret code store with factory value and comparator
`timescale 1ns/100ps
`default_nettype none
`include "rke_consts.vh"
module rke_code_store #(
  parameter SB = `RKE_SECRET_BITS,
  parameter [SB-1:0] FACTORY = `RKE_FACTORY_CODE
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          wr_en,
  input  wire          wr_slot,
  input  wire [SB-1:0] wr_code,
  input  wire [SB-1:0] cmp_code,
  output wire          match,
  output wire [SB-1:0] slot0,
  output wire [SB-1:0] slot1
);
  reg [SB-1:0] mem_r [0:1];

  // both slots hold the one shipped code after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_r[0] <= FACTORY;
      mem_r[1] <= FACTORY;
    end else if (wr_en) begin
      mem_r[wr_slot] <= wr_code;
    end
  end

  assign match = (cmp_code == mem_r[0]) || (cmp_code == mem_r[1]);
  assign slot0 = mem_r[0];
  assign slot1 = mem_r[1];
endmodule
`default_nettype wire

// [rtl/rke_ctrl.v]
// remote entry receiver control: press handling, confirmation, relock, inhibit, apb
`timescale 1ns/100ps
`default_nettype none
`include "rke_consts.vh"
module rke_ctrl #(
  parameter        NDOOR    = 4,
  parameter [31:0] TICK_CYC = `RKE_TICK_CYC
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata_r,
  output reg              pready_r,
  output reg              pslverr_r,
  input  wire             rx_gate,
  input  wire             rx_bclk,
  input  wire             rx_data,
  input  wire [1:0]       reg_sw,
  input  wire             key_in,
  input  wire [NDOOR-1:0] door_open,
  input  wire             act_unlocked,
  output reg              lock_req_r,
  output reg              unlock_req_r,
  output reg              dome_r
);
  localparam SB = `RKE_SECRET_BITS;
  localparam NB = `RKE_CODE_BITS;

  wire          code_vld;
  wire [NB-1:0] code;
  wire          match;
  wire [SB-1:0] slot0;
  wire [SB-1:0] slot1;
  reg  [1:0]    regsw1_r, regsw2_r;
  reg  [1:0]    misc1_r, misc2_r;
  reg  [NDOOR-1:0] door1_r, door2_r;
  reg           act_prev_r;
  reg  [31:0]   ctrl_r;
  reg  [31:0]   tick_cnt_r;
  reg           tick_r;
  reg  [6:0]    gap_r;
  reg           press_on_r, press_done_r;
  reg           wrote_r, wr_en_r;
  reg  [7:0]    drive_r;
  reg           conf_arm_r;
  reg  [11:0]   dome_cnt_r;
  reg  [1:0]    dome_mode_r; // 0 idle, 1 steady, 2 flash
  reg           relock_on_r;
  reg  [14:0]   relock_cnt_r;
  reg           win_on_r;
  reg  [15:0]   win_cnt_r;
  reg  [4:0]    mis_cnt_r;
  reg           inh_r;
  reg  [19:0]   inh_cnt_r;
  reg  [SB:0]   last_r;

  wire [1:0] regsw_s  = regsw2_r;
  wire       key_s    = misc2_r[0];
  wire       act_s    = misc2_r[1];
  wire       any_door = |door2_r;
  wire       reg_mode = |regsw_s;
  wire       blocked  = key_s || any_door || inh_r || !ctrl_r[`RKE_CTRL_EN];
  wire       take     = code_vld && !blocked;
  wire       cmd_unl  = code[`RKE_CMD_BIT];
  wire       hit      = take && !reg_mode && match && !press_done_r;
  wire       relock_fire = relock_on_r && tick_r && (relock_cnt_r == `RKE_RELOCK_MS - 1);
  wire       press_end   = press_on_r && tick_r && (gap_r == `RKE_PRESS_GAP_MS - 1);
  wire       miss        = press_end && !press_done_r && !reg_mode;

  rke_frame_rx #(.NB(NB)) u_rx (
    .pclk       (pclk),
    .presetn    (presetn),
    .rx_gate    (rx_gate),
    .rx_bclk    (rx_bclk),
    .rx_data    (rx_data),
    .code_vld_r (code_vld),
    .code_r     (code)
  );

  rke_code_store #(.SB(SB)) u_store (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (wr_en_r),
    .wr_slot  (last_r[SB] ),
    .wr_code  (last_r[SB-1:0]),
    .cmp_code (code[SB-1:0]),
    .match    (match),
    .slot0    (slot0),
    .slot1    (slot1)
  );

  // pin synchronisers; nothing but the second stage reads the first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regsw1_r <= 2'h0;
      regsw2_r <= 2'h0;
      misc1_r  <= 2'h0;
      misc2_r  <= 2'h0;
      door1_r  <= {NDOOR{1'b0}};
      door2_r  <= {NDOOR{1'b0}};
    end else begin
      regsw1_r <= reg_sw;
      regsw2_r <= regsw1_r;
      misc1_r  <= {act_unlocked, key_in};
      misc2_r  <= misc1_r;
      door1_r  <= door_open;
      door2_r  <= door1_r;
    end
  end

  // millisecond tick; long times count ticks so counters stay narrow
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0;
      tick_r     <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_CYC - 32'h1);
      if (tick_cnt_r == TICK_CYC - 32'h1)
        tick_cnt_r <= 32'h0;
      else
        tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // press grouping: the codes of one press act at most once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      press_on_r   <= 1'b0;
      press_done_r <= 1'b0;
      gap_r        <= 7'h00;
      wrote_r      <= 1'b0;
      wr_en_r      <= 1'b0;
      last_r       <= {(SB+1){1'b0}};
    end else begin
      wr_en_r <= 1'b0;
      if (!reg_mode)
        wrote_r <= 1'b0;
      if (take) begin
        press_on_r <= 1'b1;
        gap_r      <= 7'h00;
        if (reg_mode && !wrote_r) begin
          last_r  <= {regsw_s[1], code[SB-1:0]};
          wr_en_r <= 1'b1;
          wrote_r <= 1'b1;
        end
        if (hit)
          press_done_r <= 1'b1;
      end else if (press_end) begin
        press_on_r   <= 1'b0;
        press_done_r <= 1'b0;
      end else if (press_on_r && tick_r) begin
        gap_r <= gap_r + 7'h01;
      end
    end
  end

  // lock and unlock requests to the body controller, held for a drive time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_req_r   <= 1'b0;
      unlock_req_r <= 1'b0;
      drive_r      <= 8'h00;
      conf_arm_r   <= 1'b0;
    end else begin
      if (hit || relock_fire) begin
        lock_req_r   <= relock_fire || !cmd_unl;
        unlock_req_r <= !relock_fire && cmd_unl;
        drive_r      <= 8'h00;
        conf_arm_r   <= ctrl_r[`RKE_CTRL_CONFIRM];
      end else if ((lock_req_r || unlock_req_r) && tick_r) begin
        if (drive_r == `RKE_DRIVE_MS - 1) begin
          lock_req_r   <= 1'b0;
          unlock_req_r <= 1'b0;
        end else begin
          drive_r <= drive_r + 8'h01;
        end
      end
      // the arm lasts while the request drives, so unrelated switch moves show nothing
      if (act_s != act_prev_r)
        conf_arm_r <= 1'b0;
      else if (!lock_req_r && !unlock_req_r && !hit && !relock_fire)
        conf_arm_r <= 1'b0;
    end
  end

  // confirmation pattern, started by the actuator switch changing state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_prev_r  <= 1'b0;
      dome_mode_r <= 2'h0;
      dome_cnt_r  <= 12'h000;
      dome_r      <= 1'b0;
    end else begin
      act_prev_r <= act_s;
      if (conf_arm_r && (act_s != act_prev_r)) begin
        dome_mode_r <= act_s ? 2'h1 : 2'h2;
        dome_cnt_r  <= 12'h000;
        dome_r      <= 1'b1;
      end else if (tick_r) begin
        case (dome_mode_r)
          2'h1: begin
            if (dome_cnt_r == `RKE_CONFIRM_MS - 1) begin
              dome_mode_r <= 2'h0;
              dome_r      <= 1'b0;
            end else begin
              dome_cnt_r <= dome_cnt_r + 12'h001;
            end
          end
          2'h2: begin
            // on, off, on, off: two flashes
            if (dome_cnt_r == 4 * `RKE_FLASH_MS - 1) begin
              dome_mode_r <= 2'h0;
              dome_r      <= 1'b0;
            end else begin
              dome_cnt_r <= dome_cnt_r + 12'h001;
              dome_r     <= ((dome_cnt_r + 12'h001) / `RKE_FLASH_MS) % 2 == 0;
            end
          end
          default: dome_r <= 1'b0;
        endcase
      end
    end
  end

  // relock timer: armed by a remote unlock, dropped by any door opening
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relock_on_r  <= 1'b0;
      relock_cnt_r <= 15'h0000;
    end else begin
      if (hit && cmd_unl) begin
        relock_on_r  <= ctrl_r[`RKE_CTRL_RELOCK];
        relock_cnt_r <= 15'h0000;
      end else if (any_door || relock_fire) begin
        relock_on_r <= 1'b0;
      end else if (relock_on_r && tick_r) begin
        relock_cnt_r <= relock_cnt_r + 15'h0001;
      end
    end
  end

  // mismatch window and inhibit period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_on_r  <= 1'b0;
      win_cnt_r <= 16'h0000;
      mis_cnt_r <= 5'h00;
      inh_r     <= 1'b0;
      inh_cnt_r <= 20'h00000;
    end else begin
      if (hit) begin
        mis_cnt_r <= 5'h00;
        win_on_r  <= 1'b0;
      end else if (miss) begin
        if (mis_cnt_r == `RKE_MIS_LIMIT - 1) begin
          inh_r     <= 1'b1;
          inh_cnt_r <= 20'h00000;
          mis_cnt_r <= 5'h00;
          win_on_r  <= 1'b0;
        end else begin
          mis_cnt_r <= mis_cnt_r + 5'h01;
          if (!win_on_r) begin
            win_on_r  <= 1'b1;
            win_cnt_r <= 16'h0000;
          end
        end
      end else if (win_on_r && tick_r) begin
        if (win_cnt_r == `RKE_MISWIN_MS - 1) begin
          win_on_r  <= 1'b0;
          mis_cnt_r <= 5'h00;
        end else begin
          win_cnt_r <= win_cnt_r + 16'h0001;
        end
      end
      if (inh_r && tick_r) begin
        if (inh_cnt_r == `RKE_INHIBIT_MS - 1)
          inh_r <= 1'b0;
        else
          inh_cnt_r <= inh_cnt_r + 20'h00001;
      end
    end
  end

  // apb slave: one wait-free access phase, error on unmapped offsets
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `RKE_CTRL_RST;
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          `RKE_OFS_CTRL:   prdata_r <= ctrl_r;
          `RKE_OFS_STATUS: prdata_r <= {19'h0, mis_cnt_r, 4'h0, dome_r, relock_on_r,
                                        inh_r, reg_mode};
          `RKE_OFS_SLOT0:  prdata_r <= {11'h0, slot0};
          `RKE_OFS_SLOT1:  prdata_r <= {11'h0, slot1};
          `RKE_OFS_LAST:   prdata_r <= {10'h0, last_r};
          default: begin
            prdata_r  <= 32'h0;
            pslverr_r <= 1'b1;
          end
        endcase
      end
      if (psel && penable && pready_r && pwrite && (paddr == `RKE_OFS_CTRL))
        ctrl_r <= {29'h0, pwdata[2:0]};
    end
  end
endmodule
`default_nettype wire

// [test/rke_tx_model.sv]
// handheld sender model: lead-in, then three gated data codes
`timescale 1ns/100ps
`default_nettype none
module rke_tx_model (
  input  wire logic pclk,
  output var logic  rx_gate,
  output var logic  rx_bclk,
  output var logic  rx_data
);
  // sender's indicator lamp: lit while a switch is held, i.e. for the whole press
  logic ind_on;
  initial begin
    ind_on  = 1'b0;
    rx_gate = 1'b0;
    rx_bclk = 1'b0;
    rx_data = 1'b0;
  end
  // one bit: data first, then a bit clock pulse hb cycles wide
  task automatic bit_out(input logic b, input int hb);
    rx_data <= b;
    repeat (hb) @(posedge pclk);
    rx_bclk <= 1'b1;
    repeat (hb) @(posedge pclk);
    rx_bclk <= 1'b0;
  endtask
  // hb sets the bit rate, so a slow sender is the same call
  task automatic press(input logic [50:0] c0, c1, c2, input int hb);
    logic [50:0] c;
    ind_on <= 1'b1;
    for (int i = 0; i < 8; i++) bit_out(i[0], hb);
    for (int k = 0; k < 3; k++) begin
      c = (k == 0) ? c0 : (k == 1) ? c1 : c2;
      rx_gate <= 1'b1;
      repeat (hb) @(posedge pclk);
      for (int i = 50; i >= 0; i--) bit_out(c[i], hb);
      rx_gate <= 1'b0;
      // released line must not keep the last bit
      rx_data <= ~c[0];
      repeat (8 * hb) @(posedge pclk);
    end
    ind_on <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/rke_ctrl_props.sv]
// port assertions for the receiver control block
`timescale 1ns/100ps
`default_nettype none
module rke_ctrl_props #(
  parameter [31:0] TICK_CYC = 32'd50000
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready_r,
  input wire logic [1:0] reg_sw,
  input wire logic       key_in,
  input wire logic       act_unlocked,
  input wire logic       lock_req_r,
  input wire logic       unlock_req_r,
  input wire logic       dome_r
);
  localparam int T = TICK_CYC;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] kcnt_r, ucnt_r, dcnt_r;
  // run lengths; tick phase allows one tick of slack on each length
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kcnt_r <= 32'h0;
      ucnt_r <= 32'h0;
      dcnt_r <= 32'h0;
    end else begin
      kcnt_r <= key_in ? kcnt_r + 32'h1 : 32'h0;
      ucnt_r <= unlock_req_r ? ucnt_r + 32'h1 : 32'h0;
      dcnt_r <= dome_r ? dcnt_r + 32'h1 : 32'h0;
    end
  end
  property p_rdy; psel && !penable |=> pready_r; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready in access cycle");
  property p_one; pready_r |=> !pready_r; endproperty
  a_one: assert property (p_one) else $error("ready longer than a cycle");
  property p_excl; !(lock_req_r && unlock_req_r); endproperty
  a_excl: assert property (p_excl) else $error("lock and unlock together");
  property p_key; $rose(unlock_req_r) |-> kcnt_r < 32'd8; endproperty
  a_key: assert property (p_key) else $error("unlock with key in");
  property p_reg; $rose(unlock_req_r) |-> $past(reg_sw, 8) == 2'h0; endproperty
  a_reg: assert property (p_reg) else $error("unlock in registration");
  property p_drv;
    $fell(unlock_req_r) |-> ucnt_r >= 199 * T && ucnt_r <= 201 * T;
  endproperty
  a_drv: assert property (p_drv) else $error("request length");
  property p_std;
    $fell(dome_r) && act_unlocked |-> dcnt_r >= 2999 * T && dcnt_r <= 3001 * T;
  endproperty
  a_std: assert property (p_std) else $error("steady light length");
  property p_fl;
    $fell(dome_r) && !act_unlocked |-> dcnt_r >= 249 * T && dcnt_r <= 251 * T;
  endproperty
  a_fl: assert property (p_fl) else $error("flash length");
  property p_conf; $rose(act_unlocked) && unlock_req_r |-> ##[1:12] dome_r; endproperty
  a_conf: assert property (p_conf) else $error("no confirmation");
  c_ul: cover property ($rose(unlock_req_r));
  c_lk: cover property ($rose(lock_req_r));
  c_fl: cover property ($fell(dome_r) && !act_unlocked);
endmodule
bind rke_ctrl rke_ctrl_props #(.TICK_CYC(TICK_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready_r(pready_r), .reg_sw(reg_sw), .key_in(key_in),
  .act_unlocked(act_unlocked), .lock_req_r(lock_req_r),
  .unlock_req_r(unlock_req_r), .dome_r(dome_r));
`default_nettype wire

// [test/tb_remote_entry_receiver_ctrl.sv]
// self-checking bench for the receiver control block
`timescale 1ns/100ps
`default_nettype none
`include "rke_consts.vh"
module tb_remote_entry_receiver_ctrl;
  localparam int T = 2;
  localparam [31:0] M21 = 32'h1fffff;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_r, dd;
  logic        pready_r, pslverr_r, rx_gate, rx_bclk, rx_data, de;
  logic [1:0]  reg_sw = 2'h0;
  logic        key_in = 1'b0;
  logic        act_unlocked = 1'b0;
  logic [3:0]  door_open = 4'h0;
  logic        lock_req_r, unlock_req_r, dome_r, lk_d, ul_d, dm_d;
  logic [24:0] sid;
  logic [20:0] fc, ra, rb, n0, n1;
  int          miscompares = 0;
  int          total_checks = 0;
  int          lk_n = 0, ul_n = 0, dm_n = 0, cyc = 0, t_ul = 0, a, b, c, i;
  always #10 pclk = ~pclk;
  rke_ctrl #(.NDOOR(4), .TICK_CYC(32'd2)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .rx_gate(rx_gate),
    .rx_bclk(rx_bclk), .rx_data(rx_data), .reg_sw(reg_sw), .key_in(key_in),
    .door_open(door_open), .act_unlocked(act_unlocked), .lock_req_r(lock_req_r),
    .unlock_req_r(unlock_req_r), .dome_r(dome_r));
  rke_tx_model u_tx (.pclk(pclk), .rx_gate(rx_gate), .rx_bclk(rx_bclk), .rx_data(rx_data));
  // edge counters; the actuator switch follows the requests like a lock motor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    lk_d <= lock_req_r;
    ul_d <= unlock_req_r;
    dm_d <= dome_r;
    if (lock_req_r === 1'b1 && lk_d === 1'b0) lk_n <= lk_n + 1;
    if (unlock_req_r === 1'b1 && ul_d === 1'b0) begin
      ul_n <= ul_n + 1;
      t_ul <= cyc;
    end
    if (dome_r === 1'b1 && dm_d === 1'b0) dm_n <= dm_n + 1;
    if (unlock_req_r === 1'b1) act_unlocked <= 1'b1;
    else if (lock_req_r === 1'b1) act_unlocked <= 1'b0;
  end
  task automatic report_and_stop;
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // apb transfer; request held until ready is sampled, idle edge after
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_r !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      report_and_stop();
    end
    dd = prdata_r;
    de = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e, msk, input logic ee);
    apb(1'b0, ad, 32'h0);
    chk(dd & msk, e, "read data");
    chk({31'h0, de}, {31'h0, ee}, "slave error");
  endtask
  function automatic logic [50:0] mk(input logic [20:0] s, input logic cm);
    mk = {4'h0, sid, cm, s};
  endfunction
  // one press, then wait past the press end; counts new requests
  task automatic press(input logic [20:0] s0, s1, s2, input logic cm, input int eu, el, hb);
    a = ul_n;
    b = lk_n;
    u_tx.press(mk(s0, cm), mk(s1, cm), mk(s2, cm), hb);
    repeat (250 * T) @(posedge pclk);
    chk(ul_n - a, eu, "unlock count");
    chk(lk_n - b, el, "lock count");
  endtask
  initial begin
    void'($urandom(30));
    fc = `RKE_FACTORY_CODE;
    sid = 25'($urandom());
    ra = 21'($urandom());
    rb = 21'($urandom());
    n0 = 21'($urandom());
    n1 = 21'($urandom());
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk(`RKE_OFS_CTRL, `RKE_CTRL_RST, 32'hffffffff, 1'b0);
    rchk(`RKE_OFS_SLOT0, {11'h0, fc}, M21, 1'b0);
    rchk(`RKE_OFS_SLOT1, {11'h0, fc}, M21, 1'b0);
    rchk(8'h14, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, `RKE_OFS_STATUS, 32'hffffffff);
    rchk(`RKE_OFS_STATUS, 32'h0, 32'h1f0f, 1'b0);
    // only the third code matches; then relock with doors shut
    press(ra, rb, fc, 1'b1, 1, 0, 1);
    chk({31'h0, dome_r}, 32'h1, "dome steady");
    c = lk_n;
    for (i = 0; i < 70000 && lk_n == c; i++) @(posedge pclk);
    if (lk_n == c) begin
      miscompares++;
      report_and_stop();
    end
    chk(32'(cyc - t_ul > 30000 * T - 20 && cyc - t_ul < 30000 * T + 20), 1, "relock");
    c = dm_n;
    repeat (1250 * T) @(posedge pclk);
    chk(dm_n - c, 2, "flash count");
    press(ra, rb, rb, 1'b1, 0, 0, 1);
    rchk(`RKE_OFS_STATUS, 32'h100, 32'h1f00, 1'b0);
    press(fc, ra, rb, 1'b0, 0, 1, 1);
    rchk(`RKE_OFS_STATUS, 32'h0, 32'h1f00, 1'b0);
    key_in <= 1'b1;
    press(fc, fc, fc, 1'b1, 0, 0, 1);
    key_in <= 1'b0;
    door_open <= 4'($urandom_range(15, 1));
    press(fc, fc, fc, 1'b1, 0, 0, 1);
    door_open <= 4'h0;
    // receiver disabled by software: a matching press must do nothing
    apb(1'b1, `RKE_OFS_CTRL, 32'hfffffff6);
    rchk(`RKE_OFS_CTRL, 32'h6, 32'hffffffff, 1'b0);
    press(fc, fc, fc, 1'b1, 0, 0, 1);
    apb(1'b1, `RKE_OFS_CTRL, `RKE_CTRL_RST);
    rchk(`RKE_OFS_STATUS, 32'h0, 32'h1f00, 1'b0);
    // registration into each slot, the slow sender on the first
    reg_sw <= 2'h1;
    repeat (8) @(posedge pclk);
    rchk(`RKE_OFS_STATUS, 32'h1, 32'h1, 1'b0);
    press(n0, n0, n0, 1'b1, 0, 0, 2);
    rchk(`RKE_OFS_SLOT0, {11'h0, n0}, M21, 1'b0);
    reg_sw <= 2'h0;
    repeat (8) @(posedge pclk);
    reg_sw <= 2'h2;
    repeat (8) @(posedge pclk);
    press(n1, n1, n1, 1'b1, 0, 0, 1);
    rchk(`RKE_OFS_SLOT1, {11'h0, n1}, M21, 1'b0);
    rchk(`RKE_OFS_SLOT0, {11'h0, n0}, M21, 1'b0);
    reg_sw <= 2'h0;
    repeat (8) @(posedge pclk);
    press(ra, n1, rb, 1'b0, 0, 1, 1);
    press(fc, fc, fc, 1'b0, 0, 0, 1);
    for (i = 0; i < 28; i++) press(ra, rb, ra, 1'b0, 0, 0, 1);
    rchk(`RKE_OFS_STATUS, 32'h1d00, 32'h1f02, 1'b0);
    press(rb, ra, rb, 1'b0, 0, 0, 1);
    rchk(`RKE_OFS_STATUS, 32'h2, 32'h2, 1'b0);
    press(n1, n1, n1, 1'b1, 0, 0, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
